// ### design/sar_adc_control_regs.sv
`default_nettype none
// Notes on behaviour
// - pair bit set makes even/odd differential
// - upper nibbles of mux registers read zero
// - differential results are two's complement
// - codes 0-7 pick inputs, 1xxx temperature
// - sar clock is system clock over divider+1
// - gain codes 1,2,4,8,16,half
// - enable low holds converter in shutdown
// - track mode 0 tracks except converting
// - done flag set on busy fall, sticky
// - busy reads running; write 1 starts soft
// - start mode picks soft, timer3, pin, timer2
// - low-power trigger tracks three sar clocks, except in pin mode
// - pin mode tracks while pin low
// - window flag sticky until software clears
// - right justify, sign extended when differential
// - left justify, low bits zero
// - result spans ten bits, ten signed bits when differential
// - busy fall raises interrupt when enabled
// - conversion takes sixteen sar clocks
module sar_adc_control_regs
    import sar_adc_pkg::*;
(
    input  wire logic        REF_CLK_I,        // system clock
    input  wire logic        RESET_N_I,        // async reset, active low
    input  wire logic        SFR_WR_I,         // register write strobe
    input  wire logic [7:0]  SFR_ADDR_I,       // register address
    input  wire logic [7:0]  SFR_WDATA_I,      // register write data
    output logic      [7:0]  SFR_RDATA_O,      // register read data
    input  wire logic        TIMER3_OVF_I,     // timer 3 overflow pulse
    input  wire logic        TIMER2_OVF_I,     // timer 2 overflow pulse
    input  wire logic        CONVERT_START_I,  // external convert-start pin
    input  wire logic        WINDOW_MATCH_I,   // window compare match pulse
    input  wire logic        INT_ENABLE_I,     // converter interrupt enable
    input  wire logic [9:0]  SAR_RESULT_I,     // raw result from sar core
    output logic             ANALOG_ON_O,      // analog section powered
    output logic             TRACK_O,          // track-and-hold tracking
    output logic             CONVERTING_O,     // sar conversion running
    output logic             SAR_TICK_O,       // sar clock tick
    output analog_sel_t      ANALOG_SEL_O,     // mux and gain selection
    output logic             DONE_IRQ_O        // conversion-done request
);
    // ------------------------------------------------------------
    // register state
    // ------------------------------------------------------------
    logic [3:0]  pair_cfg;
    logic [3:0]  chan_code;
    logic [7:0]  conv_cfg;
    logic [7:0]  conv_ctrl;
    logic [7:0]  res_low;
    logic [7:0]  res_high;
    logic [3:0]  next_pair_cfg;
    logic [3:0]  next_chan_code;
    logic [7:0]  next_conv_cfg;
    logic [7:0]  next_conv_ctrl;
    logic [7:0]  next_res_low;
    logic [7:0]  next_res_high;
    sfr_req_t    req;

    // ------------------------------------------------------------
    // sequencer state
    // ------------------------------------------------------------
    conv_state_t state;
    conv_state_t next_state;
    logic [4:0]  sar_count;
    logic [4:0]  next_sar_count;
    logic [1:0]  pin_sync;
    logic        pin_prev;
    logic        done_pulse;
    logic        busy_prev;
    logic        sar_tick;
    logic        pin_rise;
    logic        trigger;
    logic        soft_start;
    logic        enabled;
    logic        low_power;
    start_mode_t mode;
    logic        sel_diff;
    logic [2:0]  sel_pos;
    logic [9:0]  result_word;

    assign req       = '{wr: SFR_WR_I, addr: SFR_ADDR_I, wdata: SFR_WDATA_I};
    assign enabled   = conv_ctrl[BIT_ENABLE];
    assign low_power = conv_ctrl[BIT_TRACK];
    assign mode      = start_mode_t'(conv_ctrl[BIT_MODE_H:BIT_MODE_L]);
    assign pin_rise  = pin_sync[1] && !pin_prev;

    // software start only in soft mode
    assign soft_start = req.wr && req.addr == ADDR_CONV_CTRL
                        && req.wdata[BIT_BUSY] && mode == MODE_SOFT;

    always_comb
    begin
        case (mode)
            MODE_SOFT:   trigger = soft_start;
            MODE_TIMER3: trigger = TIMER3_OVF_I;
            MODE_PIN:    trigger = pin_rise;
            MODE_TIMER2: trigger = TIMER2_OVF_I;
            default:     trigger = 1'b0;
        endcase
    end

    // ------------------------------------------------------------
    // channel selection
    // ------------------------------------------------------------
    // pair lookup by even member
    always_comb
    begin
        sel_pos  = chan_code[2:0];
        sel_diff = 1'b0;
        if (!chan_code[3] && pair_cfg[chan_code[2:1]])
        begin
            sel_diff = 1'b1;
            sel_pos  = {chan_code[2:1], 1'b0};
        end
    end

    // gain codes 10x and 11x collapse
    assign ANALOG_SEL_O = '{temp_sensor: chan_code[3], pos_input: sel_pos,
                            differential: sel_diff,
                            gain: conv_cfg[GAIN_H] ?
                                  gain_t'({conv_cfg[GAIN_H:GAIN_L-0+1], 1'b0})
                                  : gain_t'(conv_cfg[GAIN_H:GAIN_L])};

    // ------------------------------------------------------------
    // sar clock
    // ------------------------------------------------------------
    // divider field sets sar period
    sar_clock_gen u_sar_clock
    (
        .REF_CLK_I (REF_CLK_I),
        .RESET_N_I (RESET_N_I),
        .run_i     (enabled),
        .divider_i (conv_cfg[DIV_H:DIV_L]),
        .tick_o    (sar_tick)
    );
    assign SAR_TICK_O = sar_tick;

    // ------------------------------------------------------------
    // conversion sequencer
    // ------------------------------------------------------------
    always_comb
    begin
        next_state     = state;
        next_sar_count = sar_count;
        done_pulse     = 1'b0;
        case (state)
            ST_IDLE:
            begin
                next_sar_count = 5'h00;
                if (enabled && trigger)
                begin
                    // pin mode converts on the rising edge
                    if (low_power && mode != MODE_PIN)
                        next_state = ST_TRACK;
                    else
                        next_state = ST_CONV;
                end
            end
            ST_TRACK:
            begin
                if (sar_tick)
                begin
                    next_sar_count = sar_count + 5'h01;
                    if (sar_count == 5'(TRACK_SAR_CLOCKS) - 5'h01)
                    begin
                        next_sar_count = 5'h00;
                        next_state     = ST_CONV;
                    end
                end
            end
            ST_CONV:
            begin
                if (sar_tick)
                begin
                    next_sar_count = sar_count + 5'h01;
                    if (sar_count == CONV_SAR_CLOCKS - 5'h01)
                    begin
                        next_sar_count = 5'h00;
                        next_state     = ST_IDLE;
                        done_pulse     = 1'b1;
                    end
                end
            end
            default:
            begin
                next_state     = ST_IDLE;
                next_sar_count = 5'h00;
            end
        endcase
        if (!enabled)
        begin
            next_state     = ST_IDLE;
            next_sar_count = 5'h00;
        end
    end

    assign ANALOG_ON_O  = enabled;
    assign CONVERTING_O = state == ST_CONV;
    assign TRACK_O = enabled && state != ST_CONV
                     && (!low_power ? 1'b1
                         : (mode == MODE_PIN ? !pin_sync[1]
                                             : state == ST_TRACK));

    // ------------------------------------------------------------
    // result formatting
    // ------------------------------------------------------------
    // ten-bit signed for differential
    assign result_word = SAR_RESULT_I;

    // ------------------------------------------------------------
    // register writes and hardware updates
    // ------------------------------------------------------------
    always_comb
    begin
        next_pair_cfg  = pair_cfg;
        next_chan_code = chan_code;
        next_conv_cfg  = conv_cfg;
        next_conv_ctrl = conv_ctrl;
        next_res_low   = res_low;
        next_res_high  = res_high;
        if (req.wr)
        begin
            case (req.addr)
                ADDR_PAIR_CFG:  next_pair_cfg  = req.wdata[3:0];
                ADDR_CHAN_SEL:  next_chan_code = req.wdata[3:0];
                ADDR_CONV_CFG:  next_conv_cfg  = req.wdata;
                ADDR_RES_LOW:   next_res_low   = req.wdata;
                ADDR_RES_HIGH:  next_res_high  = req.wdata;
                ADDR_CONV_CTRL: next_conv_ctrl = req.wdata;
                default:        next_pair_cfg  = pair_cfg;
            endcase
        end
        // busy always reflects the sequencer
        next_conv_ctrl[BIT_BUSY] = next_state != ST_IDLE;
        // window match set wins over clear
        if (WINDOW_MATCH_I)
            next_conv_ctrl[BIT_WINDOW] = 1'b1;
        if (done_pulse)
        begin
            // done set wins over software clear
            next_conv_ctrl[BIT_DONE] = 1'b1;
            // result loaded with the done flag
            if (conv_ctrl[BIT_LJUST])
            begin
                next_res_high = result_word[9:2];
                next_res_low  = {result_word[1:0], 6'h00};
            end
            else
            begin
                next_res_low  = result_word[7:0];
                next_res_high = {{6{sel_diff & result_word[9]}},
                                 result_word[9:8]};
            end
        end
    end

    always_ff @(posedge REF_CLK_I or negedge RESET_N_I)
    begin
        if (!RESET_N_I)
        begin
            pair_cfg  <= RST_PAIR_CFG[3:0];
            chan_code <= RST_CHAN_SEL[3:0];
            conv_cfg  <= RST_CONV_CFG;
            conv_ctrl <= RST_CONV_CTRL;
            res_low   <= RST_RES;
            res_high  <= RST_RES;
            state     <= ST_IDLE;
            sar_count <= 5'h00;
            pin_sync  <= 2'h0;
            pin_prev  <= 1'b0;
            busy_prev <= 1'b0;
        end
        else
        begin
            pair_cfg  <= next_pair_cfg;
            chan_code <= next_chan_code;
            conv_cfg  <= next_conv_cfg;
            conv_ctrl <= next_conv_ctrl;
            res_low   <= next_res_low;
            res_high  <= next_res_high;
            state     <= next_state;
            sar_count <= next_sar_count;
            pin_sync  <= {pin_sync[0], CONVERT_START_I};
            pin_prev  <= pin_sync[1];
            busy_prev <= conv_ctrl[BIT_BUSY];
        end
    end

    assign DONE_IRQ_O = INT_ENABLE_I && busy_prev && !conv_ctrl[BIT_BUSY];

    // ------------------------------------------------------------
    // read mux
    // ------------------------------------------------------------
    always_comb
    begin
        case (SFR_ADDR_I)
            ADDR_PAIR_CFG:  SFR_RDATA_O = {4'h0, pair_cfg};
            ADDR_CHAN_SEL:  SFR_RDATA_O = {4'h0, chan_code};
            ADDR_CONV_CFG:  SFR_RDATA_O = conv_cfg;
            ADDR_RES_LOW:   SFR_RDATA_O = res_low;
            ADDR_RES_HIGH:  SFR_RDATA_O = res_high;
            ADDR_CONV_CTRL: SFR_RDATA_O = conv_ctrl;
            default:        SFR_RDATA_O = 8'h00;
        endcase
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sequence conv_end_s;
        state == ST_CONV && sar_tick && sar_count == 5'h0F;
    endsequence

    done_set_a: assert property (@(posedge REF_CLK_I)
        disable iff (!RESET_N_I)
        conv_end_s |=> conv_ctrl[BIT_DONE] && !conv_ctrl[BIT_BUSY])
        else $error("done flag not set at conversion end");

    done_sticky_a: assert property (@(posedge REF_CLK_I)
        disable iff (!RESET_N_I)
        conv_ctrl[BIT_DONE] && !(req.wr && req.addr == ADDR_CONV_CTRL)
        |=> conv_ctrl[BIT_DONE])
        else $error("done flag cleared by hardware");

    nibble_zero_a: assert property (@(posedge REF_CLK_I)
        disable iff (!RESET_N_I)
        (SFR_ADDR_I == ADDR_PAIR_CFG || SFR_ADDR_I == ADDR_CHAN_SEL)
        |-> SFR_RDATA_O[7:4] == 4'h0)
        else $error("mux register upper nibble not zero");

    shutdown_idle_a: assert property (@(posedge REF_CLK_I)
        disable iff (!RESET_N_I)
        !enabled |-> !TRACK_O ##1 state == ST_IDLE)
        else $error("converter active while disabled");

    track_len_a: assert property (@(posedge REF_CLK_I)
        disable iff (!RESET_N_I)
        state == ST_TRACK && enabled
        |=> state == ($past(sar_tick && sar_count == 5'h02) ? ST_CONV
                                                              : ST_TRACK))
        else $error("tracking sequence wrong");

    left_zero_a: assert property (@(posedge REF_CLK_I)
        disable iff (!RESET_N_I)
        conv_end_s and (conv_ctrl[BIT_LJUST] && enabled)
        |=> res_low[5:0] == 6'h00 && res_high == $past(SAR_RESULT_I[9:2]))
        else $error("left justified layout wrong");

    right_sign_a: assert property (@(posedge REF_CLK_I)
        disable iff (!RESET_N_I)
        conv_end_s and (!conv_ctrl[BIT_LJUST] && enabled)
        |=> res_high[7:2] == {6{$past(sel_diff) && res_high[1]}})
        else $error("right justified sign extension wrong");

    irq_edge_a: assert property (@(posedge REF_CLK_I)
        disable iff (!RESET_N_I)
        (conv_end_s and (enabled && INT_ENABLE_I)) ##1 INT_ENABLE_I
        |-> DONE_IRQ_O)
        else $error("interrupt missing at busy fall");

    soft_mode_a: assert property (@(posedge REF_CLK_I)
        disable iff (!RESET_N_I)
        state == ST_IDLE && mode == MODE_SOFT && !soft_start
        |=> state == ST_IDLE)
        else $error("conversion started without software write");
endmodule
`default_nettype wire

// ### design/sar_adc_pkg.sv
`default_nettype none
package sar_adc_pkg;
    // register addresses on the special-function-register bus
    localparam logic [7:0] ADDR_PAIR_CFG  = 8'hBA;
    localparam logic [7:0] ADDR_CHAN_SEL  = 8'hBB;
    localparam logic [7:0] ADDR_CONV_CFG  = 8'hBC;
    localparam logic [7:0] ADDR_RES_LOW   = 8'hBE;
    localparam logic [7:0] ADDR_RES_HIGH  = 8'hBF;
    localparam logic [7:0] ADDR_CONV_CTRL = 8'hE8;
    // reset values
    localparam logic [7:0] RST_PAIR_CFG  = 8'h00;
    localparam logic [7:0] RST_CHAN_SEL  = 8'h00;
    localparam logic [7:0] RST_CONV_CFG  = 8'hF8;
    localparam logic [7:0] RST_RES       = 8'h00;
    localparam logic [7:0] RST_CONV_CTRL = 8'h00;
    // control register bit positions
    localparam int BIT_ENABLE = 7;
    localparam int BIT_TRACK  = 6;
    localparam int BIT_DONE   = 5;
    localparam int BIT_BUSY   = 4;
    localparam int BIT_MODE_H = 3;
    localparam int BIT_MODE_L = 2;
    localparam int BIT_WINDOW = 1;
    localparam int BIT_LJUST  = 0;
    // config register field positions
    localparam int DIV_H  = 7;
    localparam int DIV_L  = 3;
    localparam int GAIN_H = 2;
    localparam int GAIN_L = 0;
    // cycle counts in sar clocks, result width in bits
    localparam logic [1:0] TRACK_SAR_CLOCKS = 2'h3;
    localparam logic [4:0] CONV_SAR_CLOCKS  = 5'h10;
    localparam int         RES_BITS         = 10;

    typedef enum logic [1:0]
    {
        MODE_SOFT   = 2'h0,
        MODE_TIMER3 = 2'h1,
        MODE_PIN    = 2'h2,
        MODE_TIMER2 = 2'h3
    } start_mode_t;

    typedef enum logic [1:0]
    {
        ST_IDLE  = 2'h0,
        ST_TRACK = 2'h1,
        ST_CONV  = 2'h3
    } conv_state_t;

    typedef enum logic [2:0]
    {
        GAIN_X1   = 3'h0,
        GAIN_X2   = 3'h1,
        GAIN_X4   = 3'h2,
        GAIN_X8   = 3'h3,
        GAIN_X16  = 3'h4,
        GAIN_HALF = 3'h6
    } gain_t;

    // analog front end selection handed to the converter core
    typedef struct packed
    {
        logic       temp_sensor;
        logic [2:0] pos_input;
        logic       differential;
        gain_t      gain;
    } analog_sel_t;

    // register bus request
    typedef struct packed
    {
        logic       wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } sfr_req_t;
endpackage
`default_nettype wire

// ### design/sar_clock_gen.sv
`default_nettype none
// divides the system clock by divider+1 into one-cycle sar clock ticks
module sar_clock_gen
    import sar_adc_pkg::*;
(
    input  wire logic       REF_CLK_I,   // system clock
    input  wire logic       RESET_N_I,   // async reset, active low
    input  wire logic       run_i,       // count while high
    input  wire logic [4:0] divider_i,   // divide field
    output logic            tick_o       // one-cycle sar clock tick
);
    logic [4:0] count;
    logic [4:0] next_count;

    always_comb
    begin
        next_count = count;
        tick_o     = 1'b0;
        if (!run_i)
        begin
            next_count = 5'h00;
        end
        else if (count >= divider_i)
        begin
            next_count = 5'h00;
            tick_o     = 1'b1;
        end
        else
        begin
            next_count = count + 5'h01;
        end
    end

    always_ff @(posedge REF_CLK_I or negedge RESET_N_I)
    begin
        if (!RESET_N_I)
            count <= 5'h00;
        else
            count <= next_count;
    end

    // tick spacing equals divider plus one, checked for a divider of one only
    sar_period_a: assert property (@(posedge REF_CLK_I)
        disable iff (!RESET_N_I)
        (tick_o && run_i && divider_i == 5'h01)
        ##1 (run_i && divider_i == 5'h01)
        |-> !tick_o ##1 (tick_o || !run_i || divider_i != 5'h01))
        else $error("sar tick spacing wrong");
endmodule
`default_nettype wire

// ### test/sar_far_side.sv
`default_nettype none
// ----
// far side: timer overflows, start pin, analog core
// ----
module sar_far_side
(
    input  wire logic       clk_i,    // system clock
    input  wire logic       conv_i,   // conversion running
    input  wire logic [1:0] fire_i,   // 1 timer3, 2 pin, 3 timer2
    input  wire logic [9:0] value_i,  // result to present
    output logic            t3_ovf_o, // timer 3 overflow
    output logic            t2_ovf_o, // timer 2 overflow
    output logic            pin_o,    // convert-start pin
    output logic      [9:0] result_o  // raw result
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [1:0] fire_q  = 2'h0;
    logic [3:0] low_cnt = 4'h0;
    logic [9:0] junk    = 10'h155;
    assign t3_ovf_o = (fire_q == 2'h1);
    assign t2_ovf_o = (fire_q == 2'h3);
    assign pin_o    = (low_cnt == 4'h0);
    // result only valid while converting
    assign result_o = conv_i ? value_i : junk;
    always @(posedge clk_i)
    begin
        fire_q <= fire_i;
        junk   <= ~junk;
        if (fire_i == 2'h2)
            low_cnt <= 4'hF;
        else if (low_cnt != 4'h0)
            low_cnt <= low_cnt - 4'h1;
    end
endmodule
`default_nettype wire

// ### test/sar_adc_control_regs_tb_top.sv
`default_nettype none
module sar_adc_control_regs_tb_top
    import sar_adc_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic        clk    = 1'b0;
    logic        rst_n  = 1'b0;
    logic        wr     = 1'b0;
    logic [7:0]  addr   = 8'h00;
    logic [7:0]  wdata  = 8'h00;
    logic        win    = 1'b0;
    logic        int_en = 1'b0;
    logic [1:0]  fire   = 2'h0;
    logic [9:0]  value  = 10'h000;
    logic [4:0]  cur_div = 5'h1F;
    logic [7:0]  rdata;
    logic [9:0]  res;
    logic        t3, t2, pin, an_on, trk, conv, tick, irq;
    analog_sel_t sel;
    logic [7:0]  notes[$];
    int          n_mismatch = 0;
    int          num_checks = 0;
    int          seed = 32'h39fb4f85;
    always #10 clk = ~clk;
    sar_adc_control_regs DUT
    (
        .REF_CLK_I       (clk),
        .RESET_N_I       (rst_n),
        .SFR_WR_I        (wr),
        .SFR_ADDR_I      (addr),
        .SFR_WDATA_I     (wdata),
        .SFR_RDATA_O     (rdata),
        .TIMER3_OVF_I    (t3),
        .TIMER2_OVF_I    (t2),
        .CONVERT_START_I (pin),
        .WINDOW_MATCH_I  (win),
        .INT_ENABLE_I    (int_en),
        .SAR_RESULT_I    (res),
        .ANALOG_ON_O     (an_on),
        .TRACK_O         (trk),
        .CONVERTING_O    (conv),
        .SAR_TICK_O      (tick),
        .ANALOG_SEL_O    (sel),
        .DONE_IRQ_O      (irq)
    );
    sar_far_side far
    (
        .clk_i    (clk),
        .conv_i   (conv),
        .fire_i   (fire),
        .value_i  (value),
        .t3_ovf_o (t3),
        .t2_ovf_o (t2),
        .pin_o    (pin),
        .result_o (res)
    );
    // ----
    // shared tasks
    // ----
    task automatic check(input string what, input logic [15:0] seen,
                         input logic [15:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        #1;
        wr = 1'b1;
        addr = a;
        wdata = d;
        @(posedge clk);
        #1;
        wr = 1'b0;
    endtask
    task automatic rd_chk(input string what, input logic [7:0] a,
                          input logic [7:0] e);
        @(posedge clk);
        #1;
        addr = a;
        #5;
        check(what, {8'h00, rdata}, {8'h00, e});
    endtask
    task automatic pulse(input logic [1:0] src);
        fire = src;
        @(posedge clk);
        #1;
        fire = 2'h0;
    endtask
    task automatic convert(input logic [7:0] c, input logic [1:0] src,
                           input logic [7:0] nt_e);
        int i;
        notes.push_back(nt_e);
        // mode first: a start write is judged by the mode already held
        wr_reg(ADDR_CONV_CTRL, c & 8'hEF);
        if (src == 2'h0)
            wr_reg(ADDR_CONV_CTRL, c);
        else
            pulse(src);
        for (i = 0; i < 3000 && notes.size() > 0; i++)
            @(posedge clk);
        check("pending", 16'(notes.size()), 16'h0);
        notes.delete();
        repeat (3) @(posedge clk);
    endtask
    // ----
    // output watcher: sar ticks, tracking, end of conversion
    // ----
    int         tk_c = 0;
    int         tk_t = 0;
    int         gap = 0;
    int         trk_n = 0;
    logic       conv_q = 1'b0;
    logic [7:0] nt;
    always @(posedge clk)
    begin
        if (conv)
            check("track", {15'h0, trk}, 16'h0);
        // capture the tracking count before it is cleared
        if (conv && !conv_q)
            trk_n = tk_t;
        gap++;
        if (!trk)
            tk_t = 0;
        else if (tick)
            tk_t++;
        if (tick && conv)
        begin
            if (tk_c > 0)
                check("gap", 16'(gap), 16'(cur_div) + 16'h1);
            tk_c++;
        end
        if (tick)
            gap = 0;
        if (conv_q && !conv && notes.size() > 0)
        begin
            nt = notes.pop_front();
            check("ticks", 16'(tk_c), 16'h10);
            if (nt != 8'hFF)
                check("tracks", 16'(trk_n), {8'h0, nt});
            check("irq", {15'h0, irq}, {15'h0, int_en});
            tk_c = 0;
        end
        conv_q = conv;
    end
    initial
    begin
        #200000;
        n_mismatch++;
        wrap_up();
    end
    // ----
    // main sequence
    // ----
    initial
    begin
        logic [7:0] ra[7];
        logic [7:0] rv[7];
        logic [7:0] cb[6];
        logic [1:0] sr[6];
        logic [7:0] te[6];
        logic [9:0] r;
        logic [3:0] pc;
        logic [2:0] g;
        logic [7:0] c, hi, lo;
        logic       d, lj;
        int         k;
        ra = '{8'hBA, 8'hBB, 8'hBC, 8'hBE, 8'hBF, 8'hE8, 8'hBD};
        rv = '{8'h00, 8'h00, 8'hF8, 8'h00, 8'h00, 8'h00, 8'h00};
        cb = '{8'h90, 8'hD0, 8'h84, 8'h88, 8'h8C, 8'hCC};
        sr = '{2'h0, 2'h0, 2'h1, 2'h2, 2'h3, 2'h3};
        te = '{8'hFF, 8'h03, 8'hFF, 8'hFF, 8'hFF, 8'h03};
        repeat (20) @(posedge clk);
        #1;
        rst_n = 1'b1;
        for (k = 0; k < 7; k++)
            rd_chk("reset", ra[k], rv[k]);
        check("power", {15'h0, an_on}, 16'h0);
        wr_reg(ADDR_PAIR_CFG, 8'hF5);
        rd_chk("pair", ADDR_PAIR_CFG, 8'h05);
        wr_reg(ADDR_CHAN_SEL, 8'hAC);
        rd_chk("chan", ADDR_CHAN_SEL, 8'h0C);
        for (k = 0; k < 16; k++)
        begin
            pc = 4'($random(seed));
            c = 8'(k);
            d = pc[c[2:1]];
            wr_reg(ADDR_PAIR_CFG, {4'h0, pc});
            wr_reg(ADDR_CHAN_SEL, c);
            #1;
            check("temp", {15'h0, sel.temp_sensor}, {15'h0, c[3]});
            if (!c[3])
            begin
                check("diff", {15'h0, sel.differential}, {15'h0, d});
                check("pos", {13'h0, sel.pos_input},
                      {13'h0, c[2:1], c[0] & !d});
            end
        end
        for (k = 0; k < 8; k++)
        begin
            g = 3'(k);
            wr_reg(ADDR_CONV_CFG, {5'h01, g});
            #1;
            check("gain", {13'h0, sel.gain},
                  {13'h0, g[2] ? {g[2:1], 1'b0} : g});
        end
        cur_div = 5'h01;
        wr_reg(ADDR_CONV_CTRL, 8'h04);
        pulse(2'h1);
        wr_reg(ADDR_CONV_CTRL, 8'h94);
        repeat (4) @(posedge clk);
        check("idle", {15'h0, conv}, 16'h0);
        check("power", {15'h0, an_on}, 16'h1);
        rd_chk("ctrl", ADDR_CONV_CTRL, 8'h84);
        for (k = 0; k < 6; k++)
        begin
            d = k[0];
            lj = k[1];
            r = 10'($random(seed));
            r[9] = r[9] | d;
            cur_div = 5'($unsigned($random(seed)) % 3);
            wr_reg(ADDR_CONV_CFG, {cur_div, 3'h0});
            wr_reg(ADDR_PAIR_CFG, {7'h0, d});
            wr_reg(ADDR_CHAN_SEL, {7'h0, d});
            int_en = k[2] | k[0];
            value = r;
            convert(cb[k] | {7'h0, lj}, sr[k], te[k]);
            hi = lj ? r[9:2] : {{6{d & r[9]}}, r[9:8]};
            lo = lj ? {r[1:0], 6'h00} : r[7:0];
            rd_chk("high", ADDR_RES_HIGH, hi);
            rd_chk("low", ADDR_RES_LOW, lo);
            rd_chk("ctrl", ADDR_CONV_CTRL,
                   (cb[k] & 8'hEF) | {7'h0, lj} | 8'h20);
        end
        @(posedge clk);
        #1;
        win = 1'b1;
        @(posedge clk);
        #1;
        win = 1'b0;
        repeat (3) @(posedge clk);
        rd_chk("window", ADDR_CONV_CTRL, 8'hEE);
        wr_reg(ADDR_CONV_CTRL, 8'h80);
        rd_chk("clear", ADDR_CONV_CTRL, 8'h80);
        wrap_up();
    end
endmodule
`default_nettype wire
